// ===== dv/cmac_core_chk.sv
`timescale 1ns/10ps
module cmac_chk #(
    parameter logic POLL_CAPABLE = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // watched ports
    input wire logic battery_present,
    input wire logic charge_en,
    input wire logic polling_en,
    input wire logic clear_targets,
    input wire logic restore_defaults,
    input wire cmac_pkg::cmac_alarm_t alarm_flags,
    input wire logic alarm_hold
);
    import cmac_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // charging must drop right after an alarm hold or a missing battery
    chk_alarm_stops:
        assert property (alarm_hold |=> !charge_en)
        else $error("charge on under alarm hold");
    chk_absent_stops:
        assert property (!battery_present |=> !charge_en)
        else $error("charge on without battery");
    // actions are single-cycle strobes, never levels
    chk_clear_once:
        assert property (clear_targets |=> !clear_targets)
        else $error("clear pulse too long");
    chk_restore_once:
        assert property (restore_defaults |=> !restore_defaults)
        else $error("restore pulse too long");
    chk_restore_poll:
        assert property (restore_defaults |-> polling_en == POLL_CAPABLE)
        else $error("polling not back to default");
    // alarm hold tied to the stop bits of the notice
    chk_hold_cause:
        assert property ($rose(alarm_hold) |-> |alarm_flags[7:4])
        else $error("alarm hold without stop bit");
    chk_flag_sets:
        assert property ($changed(alarm_flags) && |alarm_flags[7:4]
            |-> alarm_hold) else $error("stop bit without alarm hold");
    chk_removal_clear:
        assert property ($fell(battery_present) |-> ##[1:4] !alarm_hold)
        else $error("alarm hold kept after removal");
    chk_resume_cause:
        assert property ($rose(charge_en) |-> $past(battery_present))
        else $error("charge rose without battery");
    cover property (clear_targets);
    cover property ($rose(alarm_hold));
    cover property (restore_defaults);
endmodule

bind cmac_core cmac_chk #(.POLL_CAPABLE(POLL_CAPABLE)) u_chk (
    .clk(clk), .srst(srst), .battery_present(battery_present),
    .charge_en(charge_en), .polling_en(polling_en),
    .clear_targets(clear_targets), .restore_defaults(restore_defaults),
    .alarm_flags(alarm_flags), .alarm_hold(alarm_hold)
);

// ===== dv/cmac_smb_master.sv
`timescale 1ns/10ps
module cmac_smb_master (
    // device pull-down and the level it drives
    input  wire logic sda_oe,
    input  wire logic sda_out,
    // bus lines seen by the device
    output logic      scl,
    output logic      sda
);
    logic m_sda = 1'b1;
    int   slow  = 0;
    // wired-and with the pull-up, so a release reads high
    assign sda = m_sda & ~(sda_oe & ~sda_out);
    initial scl = 1'b1;

    // one bus clock; slow stretches the low phase
    task automatic bit_io(input logic b, output logic s);
        scl = 1'b0;
        #(31 + slow) m_sda = b;
        #32 scl = 1'b1;
        s = sda;
        #62;
    endtask

    // start or stop: data moves while the clock is high
    task automatic edge_io(input logic a, input logic b);
        scl = 1'b0;
        #31 m_sda = a;
        #32 scl = 1'b1;
        #62 m_sda = b;
        #62;
    endtask

    // byte msb first, then the acknowledge bit
    task automatic byte_io(input logic [7:0] d, input logic ma,
                           output logic [7:0] q, output logic ak);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(ma, ak);
    endtask

    // word write or read, low byte first; ok drops on a nack of the address, the command or the last byte the master sends
    task automatic word(input logic [6:0] a, input logic [7:0] c,
                        input logic rd, inout logic [15:0] w,
                        output logic ok);
        logic [7:0] q;
        logic       k;
        edge_io(1'b1, 1'b0);
        byte_io({a, 1'b0}, 1'b1, q, ok);
        byte_io(c, 1'b1, q, k);
        ok = ~(ok | k);
        if (rd) begin
            edge_io(1'b1, 1'b0);
            byte_io({a, 1'b1}, 1'b1, q, k);
            byte_io(8'hff, 1'b0, w[7:0], q[0]);
            byte_io(8'hff, 1'b1, w[15:8], q[0]);
        end else begin
            byte_io(w[7:0], 1'b1, q, k);
            byte_io(w[15:8], 1'b1, q, k);
        end
        ok &= ~k;
        edge_io(1'b0, 1'b1);
    endtask
endmodule

// ===== dv/test_charger_mode_alarm_cmds.sv
`timescale 1ns/10ps
module test_charger_mode_alarm_cmds;
    import cmac_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, bp = 1'b1, cond = 1'b0;
    logic        cwr = 1'b0, vwr = 1'b0, scl, sda, oe, chg, poll, clr, sdo;
    logic        rstd, ahold, ok, hold_e = 1'b0, poll_e = 1'b1, ah_e = 1'b0;
    logic [15:0] ext = 16'h0000, w;
    cmac_alarm_t flags;
    int          error_cnt = 0, check_count = 0, n_clr = 0, n_rst = 0;

    always #5 clk = ~clk;
    // count one-cycle action pulses
    always @(posedge clk) begin
        n_clr <= n_clr + int'(clr);
        n_rst <= n_rst + int'(rstd);
    end

    cmac_core DUT (
        .clk(clk), .srst(srst), .smb_scl(scl), .smb_sda_in(sda),
        .smb_sda_out(sdo), .smb_sda_oe(oe), .battery_present(bp),
        .conditioning_done(cond), .current_target_wr(cwr),
        .voltage_target_wr(vwr), .status_ext(ext), .charge_en(chg),
        .polling_en(poll), .clear_targets(clr), .restore_defaults(rstd),
        .alarm_flags(flags), .alarm_hold(ahold)
    );
    cmac_smb_master p (.sda_oe(oe), .sda_out(sdo), .scl(scl), .sda(sda));

    task automatic cmp(string nm, logic [15:0] s, logic [15:0] e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask

    // status word expected from the tracked state
    function automatic logic [15:0] exp_st();
        return (ext & ~ST_OWN_MASK)
            | {3'h0, ah_e, 6'h00, 2'h3, 2'h0, poll_e, hold_e};
    endfunction

    task automatic state_chk();
        logic [15:0] s;
        p.word(DEV_ADDR_DFLT, CMD_STATUS, 1'b1, s, ok);
        cmp("s_ack", ok, 1'b1);
        cmp("status", s, exp_st());
        cmp("charge", chg, ~hold_e & ~ah_e & bp);
        cmp("poll", poll, poll_e);
        cmp("ahold", ahold, ah_e);
    endtask

    // mode words come from the host side only
    task automatic mode_wr(logic [15:0] m);
        int c0, r0;
        c0 = n_clr;
        r0 = n_rst;
        p.word(DEV_ADDR_DFLT, CMD_MODE, 1'b0, m, ok);
        cmp("m_ack", ok, 1'b1);
        cmp("clr", 16'(n_clr - c0), m[3]);
        cmp("rst", 16'(n_rst - r0), m[2]);
        hold_e = m[0] & ~m[2];
        poll_e = m[1] | m[2];
        ah_e &= ~m[2];
        state_chk();
    endtask

    task automatic alarm_wr(logic [15:0] a);
        p.word(DEV_ADDR_DFLT, CMD_ALARM, 1'b0, a, ok);
        cmp("a_ack", ok, 1'b1);
        cmp("flags", flags, a[15:8]);
        ah_e = (ah_e | (|a[15:12])) & ~(a == ALARM_RESTART && cond);
        state_chk();
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        void'($urandom(32'h2899));
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        ext <= 16'($urandom);
        repeat (4) @(posedge clk);
        state_chk();
        p.word(DEV_ADDR_DFLT, CMD_MODE, 1'b1, w, ok);
        cmp("m_read", w, WORD_ZERO);
        // random words with reserved bits; restore only in the last
        for (int i = 0; i < 12; i++) begin
            w = 16'($urandom);
            w[2] = (i == 11);
            p.slow = (i % 3) * 150;
            mode_wr(w);
        end
        // back to the nominal bus clock; slow words cost run time
        p.slow = 0;
        // hold keeps targets, zeroing still works, release resumes
        mode_wr(16'h0001);
        mode_wr(16'h0009);
        mode_wr(16'h0000);
        // alarm bits 15 down to 11, each with the error code bits all set
        for (int k = 0; k < 5; k++) begin
            alarm_wr(16'h8000 >> k | 16'h000f);
            @(posedge clk) cwr <= 1'b1;
            @(posedge clk) cwr <= 1'b0;
            vwr <= 1'b1;
            @(posedge clk) vwr <= 1'b0;
            repeat (4) @(posedge clk);
            ah_e = 1'b0;
            state_chk();
        end
        // restart allowed only after conditioning
        alarm_wr(16'h400f);
        alarm_wr(ALARM_RESTART);
        @(posedge clk) cond <= 1'b1;
        alarm_wr(ALARM_RESTART);
        @(posedge clk) cond <= 1'b0;
        // restore clears alarm hold; reserved bits ignored
        alarm_wr(16'h200f);
        mode_wr(16'hfff4);
        // removal clears alarm hold, insertion clears charge hold
        mode_wr(16'h0003);
        alarm_wr(16'h100f);
        @(posedge clk) bp <= 1'b0;
        ah_e = 1'b0;
        repeat (4) @(posedge clk);
        state_chk();
        @(posedge clk) bp <= 1'b1;
        hold_e = 1'b0;
        repeat (4) @(posedge clk);
        state_chk();
        // power comes back: hold and alarm hold drop, polling to default
        mode_wr(16'h0001);
        alarm_wr(16'h800f);
        @(posedge clk) srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        {hold_e, poll_e, ah_e} = 3'b010;
        repeat (4) @(posedge clk);
        state_chk();
        report_and_stop();
    end
endmodule

// ===== hw/cmac_alarm_dec.sv
`timescale 1ns/10ps
module cmac_alarm_dec (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // notice write and its word
    input  wire logic              alarm_wr,
    input  wire logic [15:0]       alarm_word,
    // conditions that release the hold
    input  wire logic              conditioning_done,
    input  wire logic              hold_release,
    // decoded state
    output cmac_pkg::cmac_alarm_t  alarm_flags,
    output logic                   alarm_hold
);
    import cmac_pkg::*;

    cmac_alarm_t alarm_r;
    logic        ahold_r;
    cmac_alarm_t word_hi;
    logic        stop_hit;
    logic        restart_hit;

    // any of the top four bits stops charging, reserved one included
    assign word_hi     = cmac_alarm_t'(alarm_word[15:8]);
    assign stop_hit    = alarm_wr & (|alarm_word[15:12]);
    assign restart_hit = alarm_wr & (alarm_word == ALARM_RESTART)
                         & conditioning_done;

    // a new stop notice wins over a release in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            alarm_r <= '0;
            ahold_r <= 1'b0;
        end else begin
            if (alarm_wr)
                alarm_r <= word_hi;
            ahold_r <= stop_hit
                       | (ahold_r & ~hold_release & ~restart_hit);
        end
    end

    assign alarm_flags = alarm_r;
    assign alarm_hold  = ahold_r;

endmodule

// ===== hw/cmac_core.sv
`timescale 1ns/10ps
module cmac_core #(
    parameter logic [6:0] DEV_ADDR   = cmac_pkg::DEV_ADDR_DFLT,
    parameter logic       POLL_CAPABLE = 1'b1
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // bus pins, data is open drain
    input  wire logic              smb_scl,
    input  wire logic              smb_sda_in,
    output logic                   smb_sda_out,
    output logic                   smb_sda_oe,
    // charger side inputs, same clock
    input  wire logic              battery_present,
    input  wire logic              conditioning_done,
    input  wire logic              current_target_wr,
    input  wire logic              voltage_target_wr,
    input  wire logic [15:0]       status_ext,
    // charger side controls
    output logic                   charge_en,
    output logic                   polling_en,
    output logic                   clear_targets,
    output logic                   restore_defaults,
    output cmac_pkg::cmac_alarm_t  alarm_flags,
    output logic                   alarm_hold
);
    import cmac_pkg::*;

    cmac_bus_t   bus;
    cmac_state_t state_r;
    cmac_state_t state_nxt;
    cmac_state_t next_r;
    cmac_state_t next_nxt;
    cmac_phase_t phase_r;
    cmac_phase_t phase_nxt;
    logic [7:0]  shift_r;
    logic [7:0]  shift_nxt;
    logic [2:0]  cnt_r;
    logic [2:0]  cnt_nxt;
    logic        done_r;
    logic        done_nxt;
    logic [7:0]  cmd_r;
    logic [7:0]  cmd_nxt;
    logic [7:0]  lo_r;
    logic [7:0]  lo_nxt;
    logic [15:0] tx_r;
    logic [15:0] tx_nxt;
    logic        txhi_r;
    logic        txhi_nxt;
    logic        mack_r;
    logic        mack_nxt;
    logic        oe_r;
    logic        oe_nxt;
    logic        wr_mode_r;
    logic        wr_mode_nxt;
    logic        wr_alarm_r;
    logic        wr_alarm_nxt;
    logic [15:0] wr_word_r;
    logic [15:0] wr_word_nxt;

    logic        hold_r;
    logic        poll_r;
    logic        bat_old_r;
    logic        cur_seen_r;
    logic        volt_seen_r;
    logic        clr_r;
    logic        rst_dflt_r;
    logic        charge_en_r;

    cmac_mode_t  mode_word;
    logic        addr_hit;
    logic        cmd_is_mode;
    logic        cmd_is_alarm;
    logic        cmd_is_status;
    logic [15:0] status_word;
    logic [15:0] read_word;
    logic        bat_in;
    logic        bat_out;
    logic        both_seen;
    logic        hold_release;
    logic        mode_restore;
    logic        mode_clear;

    // swap a word into send order, low byte first, msb first
    function automatic logic [15:0] send_order(input logic [15:0] w);
        send_order = {w[7:0], w[15:8]};
    endfunction

    cmac_pin_sync u_sync (
        .clk     (clk),
        .srst    (srst),
        .scl_pin (smb_scl),
        .sda_pin (smb_sda_in),
        .bus     (bus)
    );

    // command decode on the stored code
    assign addr_hit      = (shift_r[7:1] == DEV_ADDR);
    assign cmd_is_mode   = (cmd_r == CMD_MODE);
    assign cmd_is_alarm  = (cmd_r == CMD_ALARM);
    assign cmd_is_status = (cmd_r == CMD_STATUS);

    // own bits override the outside status sources
    assign status_word = (status_ext & ~ST_OWN_MASK)
                         | (16'(hold_r)     << ST_HOLD_POS)
                         | (16'(poll_r)     << ST_POLL_POS)
                         | (16'(1'b1)       << ST_LVL2_POS)
                         | (16'(POLL_CAPABLE) << ST_LVL3_POS)
                         | (16'(alarm_hold) << ST_AHOLD_POS);

    // mode and unknown codes read back as zero, not stale data
    assign read_word = cmd_is_status ? status_word
                                     : WORD_ZERO;

    // byte level slave sequencer
    always_comb begin
        state_nxt    = state_r;
        next_nxt     = next_r;
        phase_nxt    = phase_r;
        shift_nxt    = shift_r;
        cnt_nxt      = cnt_r;
        done_nxt     = done_r;
        cmd_nxt      = cmd_r;
        lo_nxt       = lo_r;
        tx_nxt       = tx_r;
        txhi_nxt     = txhi_r;
        mack_nxt     = mack_r;
        wr_mode_nxt  = 1'b0;
        wr_alarm_nxt = 1'b0;
        wr_word_nxt  = wr_word_r;
        if (bus.stop) begin
            state_nxt = ST_IDLE;
        end else if (bus.start) begin
            state_nxt = ST_RX;
            phase_nxt = PH_ADDR;
            cnt_nxt   = 3'h0;
            done_nxt  = 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE, ST_SKIP: begin
                    state_nxt = state_r;
                end
                ST_RX: begin
                    if (bus.rise) begin
                        shift_nxt = {shift_r[6:0], bus.sda};
                        cnt_nxt   = cnt_r + 3'h1;
                        done_nxt  = (cnt_r == BIT_LAST);
                    end else if (bus.fall && done_r) begin
                        done_nxt  = 1'b0;
                        state_nxt = ST_ACK;
                        next_nxt  = ST_RX;
                        unique case (phase_r)
                            PH_ADDR: begin
                                if (!addr_hit) begin
                                    state_nxt = ST_SKIP;
                                end else if (shift_r[0]) begin
                                    next_nxt = ST_TX;
                                    tx_nxt   = send_order(read_word);
                                    txhi_nxt = 1'b0;
                                end else begin
                                    phase_nxt = PH_CMD;
                                end
                            end
                            PH_CMD: begin
                                cmd_nxt   = shift_r;
                                phase_nxt = PH_LO;
                            end
                            PH_LO: begin
                                lo_nxt    = shift_r;
                                phase_nxt = PH_HI;
                            end
                            PH_HI: begin
                                wr_word_nxt  = {shift_r, lo_r};
                                wr_mode_nxt  = cmd_is_mode;
                                wr_alarm_nxt = cmd_is_alarm;
                                next_nxt     = ST_SKIP;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (bus.fall) begin
                        state_nxt = next_r;
                        cnt_nxt   = 3'h0;
                    end
                end
                ST_TX: begin
                    if (bus.rise) begin
                        cnt_nxt  = cnt_r + 3'h1;
                        done_nxt = (cnt_r == BIT_LAST);
                    end else if (bus.fall) begin
                        if (done_r) begin
                            done_nxt  = 1'b0;
                            state_nxt = ST_TXACK;
                        end else begin
                            tx_nxt = {tx_r[14:0], 1'b0};
                        end
                    end
                end
                ST_TXACK: begin
                    if (bus.rise) begin
                        mack_nxt = ~bus.sda;
                    end else if (bus.fall) begin
                        // a second byte only after the master acks the first
                        if (mack_r && !txhi_r) begin
                            tx_nxt    = {tx_r[14:0], 1'b0};
                            txhi_nxt  = 1'b1;
                            cnt_nxt   = 3'h0;
                            state_nxt = ST_TX;
                        end else begin
                            state_nxt = ST_SKIP;
                        end
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // pull data low for an ack or a zero data bit
    assign oe_nxt = (state_nxt == ST_ACK)
                    | ((state_nxt == ST_TX) & ~tx_nxt[15]);

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            next_r  <= ST_IDLE;
            phase_r <= PH_ADDR;
            shift_r <= 8'h00;
            cnt_r   <= 3'h0;
            done_r  <= 1'b0;
            cmd_r   <= 8'h00;
            lo_r    <= 8'h00;
        end else begin
            state_r <= state_nxt;
            next_r  <= next_nxt;
            phase_r <= phase_nxt;
            shift_r <= shift_nxt;
            cnt_r   <= cnt_nxt;
            done_r  <= done_nxt;
            cmd_r   <= cmd_nxt;
            lo_r    <= lo_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_r       <= 16'h0000;
            txhi_r     <= 1'b0;
            mack_r     <= 1'b0;
            oe_r       <= 1'b0;
            wr_mode_r  <= 1'b0;
            wr_alarm_r <= 1'b0;
            wr_word_r  <= 16'h0000;
        end else begin
            tx_r       <= tx_nxt;
            txhi_r     <= txhi_nxt;
            mack_r     <= mack_nxt;
            oe_r       <= oe_nxt;
            wr_mode_r  <= wr_mode_nxt;
            wr_alarm_r <= wr_alarm_nxt;
            wr_word_r  <= wr_word_nxt;
        end
    end

    // mode word actions; reserved field is never looked at
    assign mode_word    = cmac_mode_t'(wr_word_r);
    assign mode_restore = wr_mode_r & mode_word.restore_bit;
    assign mode_clear   = wr_mode_r & mode_word.clear_targets_bit;
    assign bat_in       = battery_present & ~bat_old_r;
    assign bat_out      = ~battery_present & bat_old_r;
    assign both_seen    = (cur_seen_r | current_target_wr)
                          & (volt_seen_r | voltage_target_wr);
    assign hold_release = both_seen | bat_out | mode_restore;

    // a write in the same cycle as insertion is newer and wins
    always_ff @(posedge clk) begin
        if (srst) begin
            hold_r <= 1'b0;
            poll_r <= POLL_CAPABLE;
        end else if (mode_restore) begin
            hold_r <= 1'b0;
            poll_r <= POLL_CAPABLE;
        end else if (wr_mode_r) begin
            hold_r <= mode_word.hold_bit;
            poll_r <= mode_word.polling_bit & POLL_CAPABLE;
        end else if (bat_in) begin
            hold_r <= 1'b0;
        end
    end

    // rewrite tracking for releasing the alarm hold
    always_ff @(posedge clk) begin
        if (srst || hold_release || wr_alarm_r) begin
            cur_seen_r  <= 1'b0;
            volt_seen_r <= 1'b0;
        end else begin
            cur_seen_r  <= cur_seen_r | current_target_wr;
            volt_seen_r <= volt_seen_r | voltage_target_wr;
        end
    end

    // one-shot pulses, battery history and the charge enable level; zeroing ignores the hold state
    always_ff @(posedge clk) begin
        if (srst) begin
            bat_old_r   <= 1'b0;
            clr_r       <= 1'b0;
            rst_dflt_r  <= 1'b0;
            charge_en_r <= 1'b0;
        end else begin
            bat_old_r   <= battery_present;
            clr_r       <= mode_clear;
            rst_dflt_r  <= mode_restore;
            charge_en_r <= ~hold_r & ~alarm_hold & battery_present;
        end
    end

    cmac_alarm_dec u_alarm (
        .clk               (clk),
        .srst              (srst),
        .alarm_wr          (wr_alarm_r),
        .alarm_word        (wr_word_r),
        .conditioning_done (conditioning_done),
        .hold_release      (hold_release),
        .alarm_flags       (alarm_flags),
        .alarm_hold        (alarm_hold)
    );

    // targets live outside; hold only gates the enable
    assign charge_en        = charge_en_r;
    assign polling_en       = poll_r;
    assign clear_targets    = clr_r;
    assign restore_defaults = rst_dflt_r;
    assign smb_sda_out      = 1'b0;
    assign smb_sda_oe       = oe_r;

endmodule

// ===== hw/cmac_pin_sync.sv
`timescale 1ns/10ps
module cmac_pin_sync (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // raw bus pins
    input  wire logic              scl_pin,
    input  wire logic              sda_pin,
    // synchronised lines and events
    output cmac_pkg::cmac_bus_t    bus
);
    import cmac_pkg::*;

    logic [1:0] scl_meta_r;
    logic [1:0] sda_meta_r;
    logic       scl_old_r;
    logic       sda_old_r;

    // two stages, then one more for edge finding; idle bus is high
    always_ff @(posedge clk) begin
        if (srst) begin
            scl_meta_r <= 2'h3;
            sda_meta_r <= 2'h3;
            scl_old_r  <= 1'b1;
            sda_old_r  <= 1'b1;
        end else begin
            scl_meta_r <= {scl_meta_r[0], scl_pin};
            sda_meta_r <= {sda_meta_r[0], sda_pin};
            scl_old_r  <= scl_meta_r[1];
            sda_old_r  <= sda_meta_r[1];
        end
    end

    // start and stop are data edges while the clock stays high
    assign bus.scl   = scl_meta_r[1];
    assign bus.sda   = sda_meta_r[1];
    assign bus.rise  = scl_meta_r[1] & ~scl_old_r;
    assign bus.fall  = ~scl_meta_r[1] & scl_old_r;
    assign bus.start = scl_meta_r[1] & scl_old_r & sda_old_r
                       & ~sda_meta_r[1];
    assign bus.stop  = scl_meta_r[1] & scl_old_r & ~sda_old_r
                       & sda_meta_r[1];

endmodule

// ===== hw/cmac_pkg.sv
package cmac_pkg;

    // command codes carried in the second byte of a transfer
    localparam logic [7:0]  CMD_MODE      = 8'h12;
    localparam logic [7:0]  CMD_STATUS    = 8'h13;
    localparam logic [7:0]  CMD_ALARM     = 8'h16;

    // own bus address, seven bits; value is arbitrary
    localparam logic [6:0]  DEV_ADDR_DFLT = 7'h2a;

    // alarm word that may allow charging to restart
    localparam logic [15:0] ALARM_RESTART = 16'h0800;
    localparam logic [15:0] WORD_ZERO     = 16'h0000;

    // status word positions driven by this block
    localparam int          ST_HOLD_POS   = 0;
    localparam int          ST_POLL_POS   = 1;
    localparam int          ST_LVL2_POS   = 4;
    localparam int          ST_LVL3_POS   = 5;
    localparam int          ST_AHOLD_POS  = 12;
    localparam logic [15:0] ST_OWN_MASK   = 16'h1033;

    // last bit index of a byte
    localparam logic [2:0]  BIT_LAST      = 3'h7;

    // mode word, bit 0 at the right
    typedef struct packed {
        logic [11:0] rsv;
        logic        clear_targets_bit;
        logic        restore_bit;
        logic        polling_bit;
        logic        hold_bit;
    } cmac_mode_t;

    // upper byte of the alarm notice word
    typedef struct packed {
        logic overcharge_flag;
        logic stop_charge_flag;
        logic rsv13;
        logic overheat_flag;
        logic stop_discharge_flag;
        logic rsv10;
        logic low_capacity_flag;
        logic low_runtime_flag;
    } cmac_alarm_t;

    // synchronised bus lines and their events
    typedef struct packed {
        logic scl;
        logic sda;
        logic rise;
        logic fall;
        logic start;
        logic stop;
    } cmac_bus_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RX    = 3'b001,
        ST_ACK   = 3'b010,
        ST_TX    = 3'b011,
        ST_TXACK = 3'b100,
        ST_SKIP  = 3'b101
    } cmac_state_t;

    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_CMD  = 2'b01,
        PH_LO   = 2'b10,
        PH_HI   = 2'b11
    } cmac_phase_t;

endpackage
